// [src/ecr_mask_gen.sv]
/*
  wrap-capable 64-bit mask generator, purely combinational.
  assumes the caller registers whatever it builds from the mask.
*/
module ecr_mask_gen (
  ecr_mask_if.gen m
);
  logic [ecr_pkg::POS_W-1:0] pos;

  always_comb
  begin
    pos = ecr_pkg::POS_BOT;
    for (int i = 0; i < ecr_pkg::DW; i++)
    begin
      pos = ecr_pkg::POS_W'(i);
      // position i lives at bit 63-i
      if (m.begin_pos <= m.end_pos)
        m.mask[ecr_pkg::DW-1-i] = (pos >= m.begin_pos) && (pos <= m.end_pos); // RQ8
      else
        m.mask[ecr_pkg::DW-1-i] = (pos >= m.begin_pos) || (pos <= m.end_pos); // RQ9 RQ10
    end
  end
endmodule : ecr_mask_gen

// [src/ecr_mask_if.sv]
/*
  carrier between the datapath and its mask generator.
  assumes big-endian position numbering: position 0 is bit 63.
*/
interface ecr_mask_if;
  logic [ecr_pkg::POS_W-1:0] begin_pos;
  logic [ecr_pkg::POS_W-1:0] end_pos;
  logic [ecr_pkg::DW-1:0] mask;
  modport gen (input begin_pos, input end_pos, output mask);
  modport user (output begin_pos, output end_pos, input mask);
endinterface : ecr_mask_if

// [src/ecr_pkg.sv]
/*
  constants and types for the extend / count / rotate-mask unit.
  assumes one 200 MHz core clock and 32-bit AXI4-Lite register access.
*/
package ecr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DW = 64;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int POS_W = 6;
  localparam int CNT_W = 7;
  localparam int OP_W = 4;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SRC_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SRC_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TGT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TGT_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_XER = 8'h18;
  // control register fields
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_REC = 4;
  localparam int CTL_M64 = 5;
  localparam int CTL_WORD = 6;
  localparam int CTL_AMT_LSB = 8;
  localparam int CTL_MB_LSB = 16;
  localparam int CTL_ME_LSB = 24;
  // status and exception register fields
  localparam int CR_LT = 3;
  localparam int CR_GT = 2;
  localparam int CR_EQ = 1;
  localparam int CR_SO = 0;
  localparam int STAT_BUSY = 8;
  localparam int XER_SO = 2;
  localparam int XER_OV = 1;
  localparam int XER_CA = 0;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DW-1:0] GPR_RST = 64'h0000_0000_0000_0000;
  localparam logic [2:0] XER_RST = 3'h0;
  localparam logic [3:0] CR_RST = 4'h0;
  localparam logic [POS_W-1:0] POS_TOP = 6'h3F;
  localparam logic [POS_W-1:0] POS_BOT = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [OP_W-1:0] {
    OP_HALF_EXT,
    OP_WORD_EXT,
    OP_CLZ_WORD,
    OP_CLZ_DWORD,
    OP_CLR_LEFT,
    OP_CLR_RIGHT,
    OP_CLR,
    OP_ROT_AND,
    OP_ROT_INS
  } ecr_op_t;
endpackage : ecr_pkg

// [src/ecr_unit.sv]
/*
  extend / count-leading-zeros / rotate-and-mask execution unit behind an AXI4-Lite slave.
  assumes a single-outstanding master; a control write launches one operation.
*/
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
// Operation
// RQ1: half extend copies low 16 bits, fills above with source bit 48.
// RQ2: word extend copies low 32 bits, fills above with source bit 32.
// RQ3: word zero count starts at bit 32, result 0 to 32.
// RQ4: doubleword zero count starts at bit 0, result 0 to 64.
// RQ5: record form of a zero count clears the negative flag.
// RQ6: doubleword rotate left, bits leaving position 0 re-enter at the bottom.
// RQ7: word rotate works on two copies of source bits 32-63.
// RQ8: mask holds ones from start through stop when start not above stop.
// RQ9: start above stop wraps ones through the top and from position 0.
// RQ10: no start and stop pair gives an all-zero mask.
// RQ11: record form sets comparison bits from the final target value.
// RQ12: rotates leave summary overflow, overflow and carry untouched.
// RQ13: insert mode takes rotated bits under mask, keeps others.
// RQ14: and mode ands rotated value with mask.
// RQ15: clear-left rotate masks begin field through bit 63.
// RQ16: clear-right rotate masks bit 0 through end field.
// RQ17: clear rotate masks begin field through 63 minus amount.
// RQ18: record extends update condition field zero, plain ones do not.
// RQ19: software rotates right by n as left by 64-n or 32-n.
// RQ20: 64-bit mode compares full result, 32-bit mode the extended low word.
// RQ21: extends and counts leave exception flags untouched.
// RQ22: amounts and mask fields are six-bit unsigned positions.
// RQ23: result lands in the target before anything can read it.
module ecr_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ecr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ecr_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ecr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ecr_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  logic awready_q;
  logic wready_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [ecr_pkg::ADDR_W-1:0] aw_addr_q;
  logic [ecr_pkg::DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [ecr_pkg::DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [ecr_pkg::DW-1:0] src_q;
  logic [ecr_pkg::DW-1:0] tgt_q;
  logic [ecr_pkg::DATA_W-1:0] ctrl_q;
  logic [2:0] xer_q;
  logic [3:0] cr0_q;
  logic exec_q;
  logic do_wr;
  ecr_pkg::ecr_op_t op;
  logic rec;
  logic m64;
  logic word_src;
  logic [ecr_pkg::POS_W-1:0] amt;
  logic [ecr_pkg::DW-1:0] rot_in;
  logic [ecr_pkg::DW-1:0] rot;
  logic [ecr_pkg::DW-1:0] res_d;
  logic res_wr;
  logic is_clz;
  logic [ecr_pkg::DW-1:0] cmp;
  logic [3:0] cr_d;

  ecr_mask_if mif ();

  ecr_mask_gen u_mask (
    .m(mif.gen)
  );

  function automatic logic [ecr_pkg::DATA_W-1:0] merge_strb(
    input logic [ecr_pkg::DATA_W-1:0] old,
    input logic [ecr_pkg::DATA_W-1:0] data,
    input logic [3:0] strb
  );
    logic [ecr_pkg::DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = data[8*b +: 8];
    return r;
  endfunction : merge_strb

  function automatic logic [ecr_pkg::CNT_W-1:0] clz64(
    input logic [ecr_pkg::DW-1:0] v
  );
    logic [ecr_pkg::CNT_W-1:0] n;
    n = ecr_pkg::CNT_W'(ecr_pkg::DW);
    // highest set bit wins since it is visited last
    for (int i = 0; i < ecr_pkg::DW; i++)
      if (v[i])
        n = ecr_pkg::CNT_W'(ecr_pkg::DW - 1 - i);
    return n;
  endfunction : clz64

  function automatic logic [ecr_pkg::DW-1:0] rotate_doubleword_op(
    input logic [ecr_pkg::DW-1:0] v,
    input logic [ecr_pkg::POS_W-1:0] n
  );
    logic [2*ecr_pkg::DW-1:0] t;
    t = {v, v} << n;
    return t[2*ecr_pkg::DW-1 -: ecr_pkg::DW];
  endfunction : rotate_doubleword_op

  function automatic logic [ecr_pkg::DW-1:0] sext_word(
    input logic [ecr_pkg::WORD_W-1:0] w
  );
    return {{(ecr_pkg::DW-ecr_pkg::WORD_W){w[ecr_pkg::WORD_W-1]}}, w};
  endfunction : sext_word

  assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;

  // write address and data are accepted independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b1;
      // low address bits are dropped so decode and bresp always agree
      aw_addr_q <= {awaddr[ecr_pkg::ADDR_W-1:2], 2'b00};
    end
    else if (do_wr)
    begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b1;
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
    else if (do_wr)
    begin
      wready_q <= 1'b1;
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= ecr_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      unique case (aw_addr_q[ecr_pkg::ADDR_W-1:2])
        ecr_pkg::OFF_SRC_LO[ecr_pkg::ADDR_W-1:2],
        ecr_pkg::OFF_SRC_HI[ecr_pkg::ADDR_W-1:2],
        ecr_pkg::OFF_TGT_LO[ecr_pkg::ADDR_W-1:2],
        ecr_pkg::OFF_TGT_HI[ecr_pkg::ADDR_W-1:2],
        ecr_pkg::OFF_CTRL[ecr_pkg::ADDR_W-1:2],
        ecr_pkg::OFF_XER[ecr_pkg::ADDR_W-1:2]: bresp_q <= ecr_pkg::RESP_OKAY;
        default: bresp_q <= ecr_pkg::RESP_SLVERR;
      endcase
    end
    else if (bvalid_q && bready)
      bvalid_q <= 1'b0;
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ecr_pkg::RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= ecr_pkg::RESP_OKAY;
      rdata_q <= '0;
      unique case (araddr[ecr_pkg::ADDR_W-1:2])
        ecr_pkg::OFF_SRC_LO[ecr_pkg::ADDR_W-1:2]: rdata_q <= src_q[ecr_pkg::DATA_W-1:0];
        ecr_pkg::OFF_SRC_HI[ecr_pkg::ADDR_W-1:2]: rdata_q <= src_q[ecr_pkg::DW-1 -: ecr_pkg::DATA_W];
        ecr_pkg::OFF_TGT_LO[ecr_pkg::ADDR_W-1:2]: rdata_q <= tgt_q[ecr_pkg::DATA_W-1:0];
        ecr_pkg::OFF_TGT_HI[ecr_pkg::ADDR_W-1:2]: rdata_q <= tgt_q[ecr_pkg::DW-1 -: ecr_pkg::DATA_W];
        ecr_pkg::OFF_CTRL[ecr_pkg::ADDR_W-1:2]: rdata_q <= ctrl_q;
        ecr_pkg::OFF_STATUS[ecr_pkg::ADDR_W-1:2]:
        begin
          rdata_q[3:0] <= cr0_q;
          rdata_q[ecr_pkg::STAT_BUSY] <= exec_q;
        end
        ecr_pkg::OFF_XER[ecr_pkg::ADDR_W-1:2]: rdata_q[2:0] <= xer_q;
        default: rresp_q <= ecr_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // source operand, control word and exception flags: software only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_q <= ecr_pkg::GPR_RST;
      ctrl_q <= ecr_pkg::CTRL_RST;
      xer_q <= ecr_pkg::XER_RST;
    end
    else if (do_wr)
    begin
      if (aw_addr_q == ecr_pkg::OFF_SRC_LO)
        src_q[ecr_pkg::DATA_W-1:0] <= merge_strb(src_q[ecr_pkg::DATA_W-1:0], w_data_q, w_strb_q);
      if (aw_addr_q == ecr_pkg::OFF_SRC_HI)
        src_q[ecr_pkg::DW-1 -: ecr_pkg::DATA_W] <= merge_strb(src_q[ecr_pkg::DW-1 -: ecr_pkg::DATA_W],
          w_data_q, w_strb_q);
      if (aw_addr_q == ecr_pkg::OFF_CTRL)
        ctrl_q <= merge_strb(ctrl_q, w_data_q, w_strb_q);
      // no operation of this unit ever writes these flags
      if (aw_addr_q == ecr_pkg::OFF_XER && w_strb_q[0]) // RQ12 RQ21
        xer_q <= w_data_q[2:0];
    end
  end

  // a control write launches exactly one operation on the next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      exec_q <= 1'b0;
    else
      exec_q <= do_wr && aw_addr_q == ecr_pkg::OFF_CTRL;
  end

  always_comb
  begin
    op = ecr_pkg::ecr_op_t'(ctrl_q[ecr_pkg::CTL_OP_LSB +: ecr_pkg::OP_W]);
    rec = ctrl_q[ecr_pkg::CTL_REC];
    m64 = ctrl_q[ecr_pkg::CTL_M64];
    word_src = ctrl_q[ecr_pkg::CTL_WORD] && (op == ecr_pkg::OP_ROT_AND || op == ecr_pkg::OP_ROT_INS);
    amt = ctrl_q[ecr_pkg::CTL_AMT_LSB +: ecr_pkg::POS_W]; // RQ22
    mif.begin_pos = ctrl_q[ecr_pkg::CTL_MB_LSB +: ecr_pkg::POS_W]; // RQ22
    mif.end_pos = ctrl_q[ecr_pkg::CTL_ME_LSB +: ecr_pkg::POS_W];
    if (op == ecr_pkg::OP_CLR_LEFT)
      mif.end_pos = ecr_pkg::POS_TOP; // RQ15
    if (op == ecr_pkg::OP_CLR_RIGHT)
      mif.begin_pos = ecr_pkg::POS_BOT; // RQ16
    if (op == ecr_pkg::OP_CLR)
      mif.end_pos = ecr_pkg::POS_TOP - amt; // RQ17
    // the duplicated word makes any six-bit amount rotate the low word correctly
    rot_in = word_src ? {src_q[ecr_pkg::WORD_W-1:0], src_q[ecr_pkg::WORD_W-1:0]} : src_q; // RQ7
    rot = rotate_doubleword_op(rot_in, amt); // RQ6
  end

  always_comb
  begin
    res_d = tgt_q;
    res_wr = 1'b1;
    is_clz = 1'b0;
    unique case (op)
      ecr_pkg::OP_HALF_EXT:
        res_d = {{(ecr_pkg::DW-ecr_pkg::HALF_W){src_q[ecr_pkg::HALF_W-1]}}, src_q[ecr_pkg::HALF_W-1:0]}; // RQ1
      ecr_pkg::OP_WORD_EXT:
        res_d = sext_word(src_q[ecr_pkg::WORD_W-1:0]); // RQ2
      ecr_pkg::OP_CLZ_WORD:
      begin
        // ones below the word cap the count at 32
        res_d = {{(ecr_pkg::DW-ecr_pkg::CNT_W){1'b0}},
          clz64({src_q[ecr_pkg::WORD_W-1:0], {ecr_pkg::WORD_W{1'b1}}})}; // RQ3
        is_clz = 1'b1;
      end
      ecr_pkg::OP_CLZ_DWORD:
      begin
        res_d = {{(ecr_pkg::DW-ecr_pkg::CNT_W){1'b0}}, clz64(src_q)}; // RQ4
        is_clz = 1'b1;
      end
      ecr_pkg::OP_CLR_LEFT, ecr_pkg::OP_CLR_RIGHT, ecr_pkg::OP_CLR, ecr_pkg::OP_ROT_AND:
        res_d = rot & mif.mask; // RQ14
      ecr_pkg::OP_ROT_INS:
        res_d = (rot & mif.mask) | (tgt_q & ~mif.mask); // RQ13
      default:
        res_wr = 1'b0;
    endcase
    cmp = m64 ? res_d : sext_word(res_d[ecr_pkg::WORD_W-1:0]); // RQ20
    cr_d[ecr_pkg::CR_LT] = cmp[ecr_pkg::DW-1] && !is_clz; // RQ5
    cr_d[ecr_pkg::CR_EQ] = cmp == '0;
    cr_d[ecr_pkg::CR_GT] = !cmp[ecr_pkg::DW-1] && cmp != '0;
    cr_d[ecr_pkg::CR_SO] = xer_q[ecr_pkg::XER_SO];
  end

  // target written one cycle after launch, at the edge where the write answer is first sampled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tgt_q <= ecr_pkg::GPR_RST;
    else if (exec_q && res_wr)
      tgt_q <= res_d; // RQ23
    else if (do_wr && aw_addr_q == ecr_pkg::OFF_TGT_LO)
      tgt_q[ecr_pkg::DATA_W-1:0] <= merge_strb(tgt_q[ecr_pkg::DATA_W-1:0], w_data_q, w_strb_q);
    else if (do_wr && aw_addr_q == ecr_pkg::OFF_TGT_HI)
      tgt_q[ecr_pkg::DW-1 -: ecr_pkg::DATA_W] <= merge_strb(tgt_q[ecr_pkg::DW-1 -: ecr_pkg::DATA_W],
        w_data_q, w_strb_q);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cr0_q <= ecr_pkg::CR_RST;
    else if (exec_q && res_wr && rec)
      cr0_q <= cr_d; // RQ11 RQ18
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  half_extend_a: assert property ( // RQ1
    exec_q && op == ecr_pkg::OP_HALF_EXT |=> tgt_q[15:0] == $past(src_q[15:0])
      && tgt_q[63:16] == {48{$past(src_q[15])}})
    else $error("half extend result wrong");

  word_extend_a: assert property ( // RQ2
    exec_q && op == ecr_pkg::OP_WORD_EXT |=> tgt_q[31:0] == $past(src_q[31:0])
      && tgt_q[63:32] == {32{$past(src_q[31])}})
    else $error("word extend result wrong");

  clz_word_a: assert property ( // RQ3
    exec_q && op == ecr_pkg::OP_CLZ_WORD |=> tgt_q <= 64'd32
      && (($past(src_q[31:0]) == '0) == (tgt_q == 64'd32)))
    else $error("word zero count out of range");

  clz_dword_a: assert property ( // RQ4
    exec_q && op == ecr_pkg::OP_CLZ_DWORD |=> tgt_q <= 64'd64
      && (($past(src_q) == '0) == (tgt_q == 64'd64)))
    else $error("doubleword zero count out of range");

  clz_lt_a: assert property ( // RQ5
    exec_q && is_clz && rec |=> !cr0_q[ecr_pkg::CR_LT])
    else $error("negative flag set after zero count");

  mask_nonzero_a: assert property ( // RQ10
    mif.mask != '0)
    else $error("all-zero mask");

  insert_keep_a: assert property ( // RQ13
    exec_q && op == ecr_pkg::OP_ROT_INS |=> ((tgt_q ^ $past(tgt_q)) & ~$past(mif.mask)) == '0)
    else $error("insert changed bits outside mask");

  and_clear_a: assert property ( // RQ14
    exec_q && op inside {ecr_pkg::OP_CLR_LEFT, ecr_pkg::OP_CLR_RIGHT, ecr_pkg::OP_CLR, ecr_pkg::OP_ROT_AND}
      |=> (tgt_q & ~$past(mif.mask)) == '0)
    else $error("and mode left bits outside mask");

  flags_hold_a: assert property ( // RQ12
    exec_q |=> $stable(xer_q))
    else $error("operation changed exception flags");

  plain_cr_a: assert property ( // RQ18
    exec_q && !rec |=> $stable(cr0_q))
    else $error("plain form changed condition field");

  result_ready_a: assert property ( // RQ23
    $rose(bvalid_q) && $past(aw_addr_q) == ecr_pkg::OFF_CTRL |-> exec_q ##1 !exec_q)
    else $error("result not landed right after launch");
endmodule : ecr_unit

// [test/ecr_host.sv]
/*
  host-side bus master with one write task and one read task, issuing AXI4-Lite cycles.
  assumes a slave that answers every request; the bench bounds every wait.
*/
module ecr_host (
  input wire logic aclk,
  output logic [ecr_pkg::ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [ecr_pkg::DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ecr_pkg::ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [ecr_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // responses are always accepted, so ready stays high and never toggles twice in one step
  initial
  begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      // only a channel still offered is released, so no signal is written twice in one step
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : ecr_host

// [test/extend_count_rotate_mask_unit_bench.sv]
/*
  self-checking bench for the extend / count / rotate-mask unit.
  assumes the host model answers bus cycles and a result is readable right after its control write.
*/
module extend_count_rotate_mask_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ecr_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [ecr_pkg::DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [2:0] fixed_point_exception_reg;
  logic [3:0] cr;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #2.5 aclk = ~aclk;

  ecr_unit uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  ecr_host h (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  task automatic close_out;
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // a hung handshake ends the run here instead of stalling forever
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  function automatic logic [63:0] rotl(input logic [63:0] v, input logic [5:0] n);
    return (v << n) | (v >> (7'd64 - 7'(n)));
  endfunction : rotl

  // position p is vector bit 63-p
  function automatic logic [63:0] mk(input logic [5:0] b, input logic [5:0] e);
    logic [63:0] m;
    for (int p = 0; p < 64; p++)
      m[63-p] = (b <= e) ? (p >= b && p <= e) : (p >= b || p <= e);
    return m;
  endfunction : mk

  function automatic logic [63:0] clz(input logic [63:0] v, input int w);
    logic [63:0] n;
    n = 64'h0;
    for (int i = w - 1; i >= 0 && !v[i]; i--)
      n++;
    return n;
  endfunction : clz

  function automatic logic [63:0] model(input logic [3:0] op, input logic [63:0] s, t, input logic wd,
    input logic [5:0] a, b, e);
    logic [63:0] r;
    r = rotl(wd ? {s[31:0], s[31:0]} : s, a);
    case (op)
      4'h0: return {{48{s[15]}}, s[15:0]};
      4'h1: return {{32{s[31]}}, s[31:0]};
      4'h2: return clz(s, 32);
      4'h3: return clz(s, 64);
      4'h4: return r & mk(b, 6'd63);
      4'h5: return r & mk(6'd0, e);
      4'h6: return r & mk(b, 6'd63 - a);
      4'h7: return r & mk(b, e);
      4'h8: return (r & mk(b, e)) | (t & ~mk(b, e));
      default: return t;
    endcase
  endfunction : model

  function automatic logic [3:0] crf(input logic [63:0] v, input logic m64, input logic so);
    logic [63:0] c;
    c = m64 ? v : {{32{v[31]}}, v[31:0]};
    return {$signed(c) < 0, $signed(c) > 0, c == 64'h0, so};
  endfunction : crf

  task automatic run(input logic [3:0] op, input logic rec, m64, wd, input logic [5:0] a, b, e,
    input logic [63:0] s, t);
    logic [63:0] x;
    logic [31:0] lo, hi;
    logic [1:0] r;
    x = model(op, s, t, wd, a, b, e);
    if (rec && op < 4'h9) cr = crf(x, m64, fixed_point_exception_reg[2]);
    h.wr(ecr_pkg::OFF_SRC_LO, s[31:0], r);
    h.wr(ecr_pkg::OFF_SRC_HI, s[63:32], r);
    h.wr(ecr_pkg::OFF_TGT_LO, t[31:0], r);
    h.wr(ecr_pkg::OFF_TGT_HI, t[63:32], r);
    h.wr(ecr_pkg::OFF_CTRL, {2'h0, e, 2'h0, b, 2'h0, a, 1'b0, wd, m64, rec, op}, r);
    check("ctrl bresp", 64'(r), 64'(ecr_pkg::RESP_OKAY));
    h.rd(ecr_pkg::OFF_TGT_LO, lo, r);
    h.rd(ecr_pkg::OFF_TGT_HI, hi, r);
    check("result", {hi, lo}, x);
    h.rd(ecr_pkg::OFF_STATUS, lo, r);
    check("status", 64'(lo), {60'h0, cr});
    h.rd(ecr_pkg::OFF_XER, lo, r);
    check("xer", 64'(lo), {61'h0, fixed_point_exception_reg});
  endtask : run

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [63:0] s;
    logic [3:0] op;
    fixed_point_exception_reg = 3'h0;
    cr = 4'h0;
    void'($urandom(60561));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++)
    begin
      h.rd(8'(4 * i), d, r);
      check("reset value", 64'(d), 64'h0);
    end
    h.rd(8'h1C, d, r);
    check("unmapped rresp", 64'(r), 64'(ecr_pkg::RESP_SLVERR));
    check("unmapped rdata", 64'(d), 64'h0);
    h.wr(ecr_pkg::OFF_STATUS, 32'hFFFF_FFFF, r);
    check("status write bresp", 64'(r), 64'(ecr_pkg::RESP_SLVERR));
    h.rd(ecr_pkg::OFF_STATUS, d, r);
    check("status after write", 64'(d), 64'h0);
    // flags are never changed by operations, so a random summary bit is copied into every status
    fixed_point_exception_reg = 3'($urandom);
    h.wr(ecr_pkg::OFF_XER, {29'h0, fixed_point_exception_reg}, r);
    run(4'h7, 1'b1, 1'b1, 1'b0, 6'd60, 6'd0, 6'd63, 64'h8000_0000_0000_0001, 64'h0);
    run(4'h8, 1'b1, 1'b0, 1'b0, 6'd0, 6'd5, 6'd5, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0);
    run(4'h7, 1'b1, 1'b1, 1'b0, 6'd3, 6'd62, 6'd1, 64'hF0F0_0000_0000_000F, 64'h0);
    for (int i = 0; i < 180; i++)
    begin
      op = 4'(i % 10);
      case (i % 6)
        0: s = 64'h0;
        1: s = 64'h0000_0000_0000_8000;
        2: s = 64'h0000_0000_8000_0000;
        default: s = {$urandom, $urandom};
      endcase
      run(op, 1'($urandom), 1'($urandom), op > 4'h6 && 1'($urandom), 6'($urandom), 6'($urandom),
        6'($urandom), s, {$urandom, $urandom});
    end
    close_out();
  end
endmodule : extend_count_rotate_mask_unit_bench
